// ===== hw/tmr8_pkg.sv
/*
 * Constants for the 8-bit timer/counter register block: register map,
 * field positions, reset values, clock-select and waveform mode codes.
 * Assumes a plain single-cycle register port and one system clock.
 */
// Notes on behaviour
// R1: Force-compare bits act only while the waveform mode is not PWM.
// R2: Software writes zero to force bits when writing control in PWM.
// R3: Force bit is a one-cycle strobe applying the current output action.
// R4: Forced compare sets no flag, asks no interrupt, never clears counter.
// R5: Force-compare bits always read back as zero.
// R6: Reserved control bits 5:4 and enable/flag bits 7:3 read zero.
// R7: Clock select 000 stops, 001 undivided, 010-101 divide 8/64/256/1024.
// R8: Clock select 110 counts pin falling edges, 111 rising edges.
// R9: Pin edges count even when the pin is driven as an output.
// R10: Counter register gives direct read and write of the 8-bit count.
// R11: Counter write blocks compare matches on the next timer tick.
// R12: Software should not modify a running counter, matches may be missed.
// R13: Compare registers compare continuously, drive flags and waveforms.
// R14: Enables in bits 2,1,0; interrupt needs enable, flag and global bit.
// R15: Compare B flag bit 2 sets on counter matching compare B.
// R16: Compare A flag bit 1 sets on counter matching compare A.
// R17: Overflow flag bit 0 sets on overflow, point depends on wave mode.
// R18: Each flag clears when its interrupt vector is executed.
// R19: Writing one to a flag clears it; zero leaves it unchanged.
// R20: Wave mode selects normal, clear-on-match or PWM; top, update, overflow.
// R21: Output action 00 off, 01 toggle, 10 clear, 11 set on match.
// R22: External count pin is synchronised and edge detected before use.
package tmr8_pkg;
    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [2:0] ADDR_CTRL_B = 3'h0;
    localparam logic [2:0] ADDR_COUNT = 3'h1;
    localparam logic [2:0] ADDR_CMP_A = 3'h2;
    localparam logic [2:0] ADDR_CMP_B = 3'h3;
    localparam logic [2:0] ADDR_IRQ_EN = 3'h4;
    localparam logic [2:0] ADDR_IRQ_FLAGS = 3'h5;
    // ------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------
    localparam int BIT_FORCE_A = 7;
    localparam int BIT_FORCE_B = 6;
    localparam int BIT_WAVE_HIGH = 3;
    localparam int BIT_CMP_B = 2;
    localparam int BIT_CMP_A = 1;
    localparam int BIT_OVF = 0;
    localparam logic [7:0] CTRL_B_READ_MASK = 8'h0f;
    localparam logic [7:0] IRQ_READ_MASK = 8'h07;
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [7:0] COUNT_MAX = 8'hff;
    localparam logic [7:0] COUNT_BOTTOM = 8'h00;
    // ------------------------------------------------------------
    // Clock select codes
    // ------------------------------------------------------------
    localparam logic [2:0] CS_STOP = 3'h0;
    localparam logic [2:0] CS_DIV1 = 3'h1;
    localparam logic [2:0] CS_DIV8 = 3'h2;
    localparam logic [2:0] CS_DIV64 = 3'h3;
    localparam logic [2:0] CS_DIV256 = 3'h4;
    localparam logic [2:0] CS_DIV1024 = 3'h5;
    localparam logic [2:0] CS_EXT_FALL = 3'h6;
    localparam logic [2:0] CS_EXT_RISE = 3'h7;
    localparam int PRESC_WIDTH = 10;
    localparam logic [9:0] PRESC_MASK_8 = 10'h007;
    localparam logic [9:0] PRESC_MASK_64 = 10'h03f;
    localparam logic [9:0] PRESC_MASK_256 = 10'h0ff;
    localparam logic [9:0] PRESC_MASK_1024 = 10'h3ff;
    // ------------------------------------------------------------
    // Waveform modes and output actions
    // ------------------------------------------------------------
    localparam logic [2:0] WM_NORMAL = 3'h0;
    localparam logic [2:0] WM_PC_FF = 3'h1;
    localparam logic [2:0] WM_CTC = 3'h2;
    localparam logic [2:0] WM_FAST_FF = 3'h3;
    localparam logic [2:0] WM_PC_CMPA = 3'h5;
    localparam logic [2:0] WM_FAST_CMPA = 3'h7;
    localparam logic [1:0] ACT_OFF = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;
endpackage

// ===== hw/tmr8_timer.sv
/*
 * 8-bit timer/counter with control B, count, two compare registers,
 * interrupt enable and write-one-to-clear flag registers.
 * Assumes a single system clock as the I/O clock, a plain register port
 * whose read data appear one cycle after the read strobe, and a core that
 * supplies the global interrupt bit and per-source vector acknowledges.
 */
// Implementation choices: the strobed register port and the address map.
`timescale 1ns/1ps
`default_nettype none
module tmr8_timer (
    // Clock and reset
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    // Register port
    input wire logic [2:0] reg_addr_in,
    input wire logic [7:0] reg_wdata_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    output logic [7:0] reg_rdata_out,
    // Control register A fields, kept outside this block
    input wire logic [1:0] wave_mode_low_in,
    input wire logic [1:0] out_action_a_in,
    input wire logic [1:0] out_action_b_in,
    // Core side: global enable and vector acknowledges (ovf, cmp a, cmp b)
    input wire logic global_irq_en_in,
    input wire logic [2:0] vector_ack_in,
    // External count pin
    input wire logic ext_count_pin_in,
    // Outputs
    output logic wave_out_a_out,
    output logic wave_out_b_out,
    output logic [2:0] irq_req_out
);
    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic wave_mode_high_reg;
    logic [2:0] clk_source_sel_reg;
    logic [7:0] timer_count_reg;
    logic [7:0] compare_value_a_reg;
    logic [7:0] compare_value_b_reg;
    logic [7:0] cmp_a_buf_reg;
    logic [7:0] cmp_b_buf_reg;
    logic [2:0] timer_irq_enable_reg;
    logic [2:0] timer_irq_flags_reg;
    logic [2:0] pin_sync_reg;
    logic pin_level_reg;
    logic [9:0] presc_reg;
    logic block_match_reg;
    logic count_down_reg;
    logic [1:0] wave_reg;
    logic [2:0] wave_mode;
    logic is_pwm;
    logic tick;
    logic [7:0] top_val;
    logic wr_ctrl, wr_count, wr_flags;
    logic match_a, match_b, at_top, at_bottom, ovf_evt;
    logic force_a, force_b;

    assign wave_mode = {wave_mode_high_reg, wave_mode_low_in};
    assign wr_ctrl = reg_wr_in && (reg_addr_in == tmr8_pkg::ADDR_CTRL_B);
    assign wr_count = reg_wr_in && (reg_addr_in == tmr8_pkg::ADDR_COUNT);
    assign wr_flags = reg_wr_in && (reg_addr_in == tmr8_pkg::ADDR_IRQ_FLAGS);

    // PWM decode is used by force gating and buffer update
    function automatic logic pwm_mode(input logic [2:0] wm);
        pwm_mode = (wm == tmr8_pkg::WM_PC_FF) || (wm == tmr8_pkg::WM_FAST_FF) ||
                   (wm == tmr8_pkg::WM_PC_CMPA) || (wm == tmr8_pkg::WM_FAST_CMPA);
    endfunction

    // Output action on a match; the same decode serves forced compares
    function automatic logic apply_action(input logic [1:0] act, input logic cur);
        case (act)
            tmr8_pkg::ACT_TOGGLE: apply_action = ~cur;
            tmr8_pkg::ACT_CLEAR: apply_action = 1'b0;
            tmr8_pkg::ACT_SET: apply_action = 1'b1;
            default: apply_action = cur;
        endcase
    endfunction

    assign is_pwm = pwm_mode(wave_mode); // see R20
    // Force strobes only in non-PWM modes; they touch no flag or counter
    assign force_a = wr_ctrl && reg_wdata_in[tmr8_pkg::BIT_FORCE_A] && !is_pwm; // see R1
    assign force_b = wr_ctrl && reg_wdata_in[tmr8_pkg::BIT_FORCE_B] && !is_pwm; // see R1

    // ------------------------------------------------------------
    // Clock selection
    // ------------------------------------------------------------
    // Pin passes three flops; the first one may go metastable, so only it reads the pin
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pin_sync_reg <= 3'h0;
        end else begin
            pin_sync_reg <= {pin_sync_reg[1:0], ext_count_pin_in}; // see R22, R9
        end
    end

    // Accepted pin level moves only once the last two stages agree, so a
    // one-cycle glitch that reaches a single stage never counts as an edge
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pin_level_reg <= 1'b0;
        end else if (pin_sync_reg[2] == pin_sync_reg[1]) begin
            pin_level_reg <= pin_sync_reg[2]; // see R22
        end
    end

    // Free-running prescaler shared by all divided rates
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            presc_reg <= '0;
        end else begin
            presc_reg <= presc_reg + 10'h001;
        end
    end

    // Timer tick: one cycle per selected clock event
    always_comb begin
        case (clk_source_sel_reg) // see R7, R8
            tmr8_pkg::CS_DIV1: tick = 1'b1;
            tmr8_pkg::CS_DIV8: tick = (presc_reg & tmr8_pkg::PRESC_MASK_8) ==
                                      tmr8_pkg::PRESC_MASK_8;
            tmr8_pkg::CS_DIV64: tick = (presc_reg & tmr8_pkg::PRESC_MASK_64) ==
                                       tmr8_pkg::PRESC_MASK_64;
            tmr8_pkg::CS_DIV256: tick = (presc_reg & tmr8_pkg::PRESC_MASK_256) ==
                                        tmr8_pkg::PRESC_MASK_256;
            tmr8_pkg::CS_DIV1024: tick = presc_reg == tmr8_pkg::PRESC_MASK_1024;
            tmr8_pkg::CS_EXT_FALL: tick = pin_level_reg && !pin_sync_reg[2] && !pin_sync_reg[1];
            tmr8_pkg::CS_EXT_RISE: tick = !pin_level_reg && pin_sync_reg[2] && pin_sync_reg[1];
            default: tick = 1'b0;
        endcase
    end

    // ------------------------------------------------------------
    // Counter and compare
    // ------------------------------------------------------------
    // Top is compare A in clear-on-match and compare-A PWM modes
    assign top_val = (wave_mode == tmr8_pkg::WM_CTC || wave_mode == tmr8_pkg::WM_PC_CMPA ||
                      wave_mode == tmr8_pkg::WM_FAST_CMPA) ? cmp_a_buf_reg :
                     tmr8_pkg::COUNT_MAX; // see R20
    assign at_top = timer_count_reg == top_val;
    assign at_bottom = timer_count_reg == tmr8_pkg::COUNT_BOTTOM;
    // Compares run continuously but are blocked after a counter write
    assign match_a = tick && !block_match_reg && (timer_count_reg == cmp_a_buf_reg); // see R13
    assign match_b = tick && !block_match_reg && (timer_count_reg == cmp_b_buf_reg); // see R13, R11

    // Overflow point per wave mode: bottom in phase-correct, top in compare-A fast PWM, MAX elsewhere
    always_comb begin
        case (wave_mode) // see R17
            tmr8_pkg::WM_PC_FF, tmr8_pkg::WM_PC_CMPA: ovf_evt = tick && at_bottom &&
                                                                count_down_reg;
            tmr8_pkg::WM_FAST_CMPA: ovf_evt = tick && at_top;
            default: ovf_evt = tick && (timer_count_reg == tmr8_pkg::COUNT_MAX);
        endcase
    end

    // Software write blocks matches until the next timer tick has passed
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            block_match_reg <= 1'b0;
        end else if (wr_count) begin
            block_match_reg <= 1'b1; // see R11
        end else if (tick) begin
            block_match_reg <= 1'b0;
        end
    end

    // Counter: software write wins; forced compares never clear it
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            timer_count_reg <= tmr8_pkg::RESET_BYTE;
            count_down_reg <= 1'b0;
        end else if (wr_count) begin
            timer_count_reg <= reg_wdata_in; // see R10
        end else if (tick) begin
            if (wave_mode == tmr8_pkg::WM_PC_FF || wave_mode == tmr8_pkg::WM_PC_CMPA) begin
                if (!count_down_reg && at_top) begin
                    count_down_reg <= 1'b1;
                    timer_count_reg <= timer_count_reg - 8'h01;
                end else if (count_down_reg && at_bottom) begin
                    count_down_reg <= 1'b0;
                    timer_count_reg <= timer_count_reg + 8'h01;
                end else if (count_down_reg) begin
                    timer_count_reg <= timer_count_reg - 8'h01;
                end else begin
                    timer_count_reg <= timer_count_reg + 8'h01;
                end
            end else if (at_top && wave_mode != tmr8_pkg::WM_NORMAL) begin
                timer_count_reg <= tmr8_pkg::COUNT_BOTTOM; // see R4, R20
                count_down_reg <= 1'b0;
            end else begin
                timer_count_reg <= timer_count_reg + 8'h01;
                count_down_reg <= 1'b0;
            end
        end
    end

    // Compare buffers: immediate in non-PWM, at top in PWM
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cmp_a_buf_reg <= tmr8_pkg::RESET_BYTE;
            cmp_b_buf_reg <= tmr8_pkg::RESET_BYTE;
        end else if (!is_pwm || (tick && ((count_down_reg == 1'b0 && at_top &&
                     wave_mode[0] && wave_mode != tmr8_pkg::WM_FAST_FF &&
                     wave_mode != tmr8_pkg::WM_FAST_CMPA) ||
                     ((wave_mode == tmr8_pkg::WM_FAST_FF ||
                       wave_mode == tmr8_pkg::WM_FAST_CMPA) && at_top)))) begin
            cmp_a_buf_reg <= compare_value_a_reg; // see R20
            cmp_b_buf_reg <= compare_value_b_reg;
        end
    end

    // ------------------------------------------------------------
    // Waveform outputs
    // ------------------------------------------------------------
    // Non-PWM: action on match or force; PWM: act on match, fast modes also load at top
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wave_reg <= 2'h0;
        end else begin
            if (force_a || (match_a && !is_pwm)) begin
                wave_reg[0] <= apply_action(out_action_a_in, wave_reg[0]); // see R3, R21
            end else if (is_pwm && match_a && out_action_a_in[1]) begin
                wave_reg[0] <= out_action_a_in[0] ^ count_down_reg;
            end else if (is_pwm && tick && at_top && !wave_mode[0] == 1'b0 &&
                         wave_mode[1] && out_action_a_in[1]) begin
                wave_reg[0] <= ~out_action_a_in[0];
            end
            if (force_b || (match_b && !is_pwm)) begin
                wave_reg[1] <= apply_action(out_action_b_in, wave_reg[1]); // see R3, R21
            end else if (is_pwm && match_b && out_action_b_in[1]) begin
                wave_reg[1] <= out_action_b_in[0] ^ count_down_reg;
            end else if (is_pwm && tick && at_top && wave_mode[1] && out_action_b_in[1]) begin
                wave_reg[1] <= ~out_action_b_in[0];
            end
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wave_out_a_out <= 1'b0;
            wave_out_b_out <= 1'b0;
        end else begin
            wave_out_a_out <= (out_action_a_in != tmr8_pkg::ACT_OFF) && wave_reg[0];
            wave_out_b_out <= (out_action_b_in != tmr8_pkg::ACT_OFF) && wave_reg[1];
        end
    end

    // ------------------------------------------------------------
    // Control and data registers
    // ------------------------------------------------------------
    // Force bits are not stored, so they cannot read back as one
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wave_mode_high_reg <= 1'b0;
            clk_source_sel_reg <= tmr8_pkg::CS_STOP;
        end else if (wr_ctrl) begin
            wave_mode_high_reg <= reg_wdata_in[tmr8_pkg::BIT_WAVE_HIGH]; // see R5
            clk_source_sel_reg <= reg_wdata_in[2:0];
        end
    end

    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            compare_value_a_reg <= tmr8_pkg::RESET_BYTE;
            compare_value_b_reg <= tmr8_pkg::RESET_BYTE;
            timer_irq_enable_reg <= 3'h0;
        end else if (reg_wr_in) begin
            if (reg_addr_in == tmr8_pkg::ADDR_CMP_A) begin
                compare_value_a_reg <= reg_wdata_in;
            end
            if (reg_addr_in == tmr8_pkg::ADDR_CMP_B) begin
                compare_value_b_reg <= reg_wdata_in;
            end
            if (reg_addr_in == tmr8_pkg::ADDR_IRQ_EN) begin
                timer_irq_enable_reg <= reg_wdata_in[2:0]; // see R14
            end
        end
    end

    // Flags: hardware set beats any clear in the same cycle
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            timer_irq_flags_reg <= 3'h0;
        end else begin
            timer_irq_flags_reg <= ((timer_irq_flags_reg &
                ~((wr_flags ? reg_wdata_in[2:0] : 3'h0) | vector_ack_in)) | // see R19, R18
                {match_b, match_a, ovf_evt}); // see R15, R16, R17, R4
        end
    end

    // Interrupt requests need enable, flag and global bit
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            irq_req_out <= 3'h0;
        end else begin
            irq_req_out <= timer_irq_enable_reg & timer_irq_flags_reg &
                           {3{global_irq_en_in}}; // see R14
        end
    end

    // Read data one cycle after the strobe; reserved bits return zero
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            reg_rdata_out <= 8'h00;
        end else if (reg_rd_in) begin
            case (reg_addr_in) // see R6
                tmr8_pkg::ADDR_CTRL_B: reg_rdata_out <= {4'h0, wave_mode_high_reg,
                                                         clk_source_sel_reg};
                tmr8_pkg::ADDR_COUNT: reg_rdata_out <= timer_count_reg;
                tmr8_pkg::ADDR_CMP_A: reg_rdata_out <= compare_value_a_reg;
                tmr8_pkg::ADDR_CMP_B: reg_rdata_out <= compare_value_b_reg;
                tmr8_pkg::ADDR_IRQ_EN: reg_rdata_out <= {5'h00, timer_irq_enable_reg};
                tmr8_pkg::ADDR_IRQ_FLAGS: reg_rdata_out <= {5'h00, timer_irq_flags_reg};
                default: reg_rdata_out <= 8'h00;
            endcase
        end else begin
            reg_rdata_out <= 8'h00;
        end
    end

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    property p_force_no_flag;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        (force_a && !match_a && !vector_ack_in[1] && !wr_flags &&
         !timer_irq_flags_reg[1]) |=> !timer_irq_flags_reg[1];
    endproperty
    a_force_no_flag: assert property (p_force_no_flag) else $error("force set flag"); // see R4
    property p_block;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        wr_count |=> !match_a && !match_b;
    endproperty
    a_block: assert property (p_block) else $error("match after count write"); // see R11
    property p_flag_set;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        match_a |=> timer_irq_flags_reg[1];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("cmp a flag missed"); // see R16
    property p_irq;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        irq_req_out[2] |-> $past(timer_irq_flags_reg[2]) && $past(global_irq_en_in);
    endproperty
    a_irq: assert property (p_irq) else $error("irq without cause"); // see R14
    property p_stop;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        (clk_source_sel_reg == tmr8_pkg::CS_STOP && !wr_count) |=> $stable(timer_count_reg);
    endproperty
    a_stop: assert property (p_stop) else $error("stopped counter moved"); // see R7
    property p_rd_zero;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        reg_rd_in && reg_addr_in == tmr8_pkg::ADDR_CTRL_B |=> reg_rdata_out[7:4] == 4'h0;
    endproperty
    a_rd_zero: assert property (p_rd_zero) else $error("reserved bits set"); // see R5
    property p_w1c;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        (wr_flags && reg_wdata_in[0] && !ovf_evt) |=> !timer_irq_flags_reg[0];
    endproperty
    a_w1c: assert property (p_w1c) else $error("flag not cleared"); // see R19
    property p_count_wr;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        wr_count |=> timer_count_reg == $past(reg_wdata_in);
    endproperty
    a_count_wr: assert property (p_count_wr) else $error("count write lost"); // see R10
    property p_force_pwm;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        (wr_ctrl && is_pwm && !tick) |=> $stable(wave_reg);
    endproperty
    a_force_pwm: assert property (p_force_pwm) else $error("force acted in pwm"); // see R1
    property p_rd_irq_zero;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        reg_rd_in && reg_addr_in >= tmr8_pkg::ADDR_IRQ_EN |=> reg_rdata_out[7:3] == 5'h00;
    endproperty
    a_rd_irq_zero: assert property (p_rd_irq_zero) else $error("reserved irq bits set"); // see R6
endmodule
`default_nettype wire

// ===== dv/tmr8_timer_test.sv
/* Self-checking bench for the 8-bit timer register block.
   Assumes the block alone, driven at its ports with no partner model. */
`timescale 1ns/1ps
`default_nettype none
module tmr8_timer_test;
    // ----------------------------------------
    // Stimulus and observed signals
    // ----------------------------------------
    logic clk_sys_in = 1'b0;
    logic resetn_in = 1'b0;
    logic [2:0] addr = 3'h0;
    logic [7:0] wdata = 8'h00;
    logic wr = 1'b0;
    logic rd = 1'b0;
    logic [1:0] wlow = 2'h0;
    logic [1:0] act_a = 2'h0;
    logic [1:0] act_b = 2'h0;
    logic gie = 1'b0;
    logic [2:0] ack = 3'h0;
    logic pin = 1'b0;
    logic [7:0] rdata;
    logic wa;
    logic wb;
    logic [2:0] irq;
    logic [7:0] d;
    int n_fail = 0;
    int check_count = 0;
    int cycles = 0;
    int divs[4] = '{8, 64, 256, 1024};
    int i;

    tmr8_timer u_dut (.clk_sys_in(clk_sys_in), .resetn_in(resetn_in), .reg_addr_in(addr),
        .reg_wdata_in(wdata), .reg_wr_in(wr), .reg_rd_in(rd), .reg_rdata_out(rdata),
        .wave_mode_low_in(wlow), .out_action_a_in(act_a), .out_action_b_in(act_b),
        .global_irq_en_in(gie), .vector_ack_in(ack), .ext_count_pin_in(pin),
        .wave_out_a_out(wa), .wave_out_b_out(wb), .irq_req_out(irq));

    // ----------------------------------------
    // Clock and hang guard
    // ----------------------------------------
    initial forever #5 clk_sys_in = ~clk_sys_in;
    // Longest test is the divide-by-1024 run, so the ceiling leaves wide margin
    always @(posedge clk_sys_in) begin
        cycles++;
        if (cycles == 30000) begin
            n_fail++;
            results();
        end
    end

    // ----------------------------------------
    // Access tasks
    // ----------------------------------------
    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        check_count++;
        if (got !== exp) begin
            n_fail++;
            $display("Error %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clk_sys_in);
    endtask
    task automatic wr_reg(input logic [2:0] a, input logic [7:0] v);
        @(posedge clk_sys_in);
        addr <= a;
        wdata <= v;
        wr <= 1'b1;
        @(posedge clk_sys_in);
        wr <= 1'b0;
    endtask
    // Read data stand only in the cycle after the strobe
    task automatic rd_reg(input logic [2:0] a, output logic [7:0] v);
        @(posedge clk_sys_in);
        addr <= a;
        rd <= 1'b1;
        @(posedge clk_sys_in);
        rd <= 1'b0;
        @(posedge clk_sys_in);
        v = rdata;
    endtask
    // Run the counter from clock source cs for about n cycles, then read it
    task automatic run(input logic [2:0] cs, input int n);
        wr_reg(tmr8_pkg::ADDR_CTRL_B, {5'h00, cs});
        idle(n);
        wr_reg(tmr8_pkg::ADDR_CTRL_B, 8'h00);
        rd_reg(tmr8_pkg::ADDR_COUNT, d);
    endtask
    task automatic results();
        $display("Checks %0d, errors %0d", check_count, n_fail);
        if (n_fail == 0 && check_count > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        idle(4);
        resetn_in <= 1'b1;
        // Reset values, including unmapped place 6
        for (i = 0; i < 7; i++) begin
            rd_reg(3'(i), d);
            check(d, 8'h00);
        end
        wr_reg(tmr8_pkg::ADDR_CTRL_B, 8'hf8);
        rd_reg(tmr8_pkg::ADDR_CTRL_B, d);
        check(d, 8'h08);
        wr_reg(tmr8_pkg::ADDR_IRQ_EN, 8'hff);
        rd_reg(tmr8_pkg::ADDR_IRQ_EN, d);
        check(d, 8'h07);
        wr_reg(tmr8_pkg::ADDR_COUNT, 8'h5a);
        idle(5);
        rd_reg(tmr8_pkg::ADDR_COUNT, d);
        check(d, 8'h5a);
        // Undivided and prescaled sources; prescaler phase is free, hence the spread
        wr_reg(tmr8_pkg::ADDR_COUNT, 8'h00);
        run(tmr8_pkg::CS_DIV1, 20);
        check(8'(d >= 8'd21 && d <= 8'd23), 8'h01);
        for (i = 0; i < 4; i++) begin
            wr_reg(tmr8_pkg::ADDR_COUNT, 8'h00);
            run(3'(i + 2), 4 * divs[i]);
            check(8'(d >= 8'd3 && d <= 8'd5), 8'h01);
        end
        // External pin, rising then falling edges
        for (i = 7; i > 5; i--) begin
            wr_reg(tmr8_pkg::ADDR_COUNT, 8'h00);
            wr_reg(tmr8_pkg::ADDR_CTRL_B, 8'(i));
            repeat (5) begin
                pin <= 1'b1;
                idle(4);
                pin <= 1'b0;
                idle(4);
            end
            run(3'(i), 6);
            check(d, 8'h05);
        end
        // Clear-on-match keeps the count at or below compare A
        wlow <= 2'h2;
        wr_reg(tmr8_pkg::ADDR_CMP_A, 8'h08);
        wr_reg(tmr8_pkg::ADDR_COUNT, 8'h00);
        run(tmr8_pkg::CS_DIV1, 40);
        check(8'(d <= 8'h08), 8'h01);
        wlow <= 2'h0;
        wr_reg(tmr8_pkg::ADDR_IRQ_FLAGS, 8'h07);
        // Both compare matches, requests, one-to-clear and vector clear
        wr_reg(tmr8_pkg::ADDR_CMP_A, 8'h20);
        wr_reg(tmr8_pkg::ADDR_CMP_B, 8'h30);
        wr_reg(tmr8_pkg::ADDR_COUNT, 8'h10);
        gie <= 1'b1;
        run(tmr8_pkg::CS_DIV1, 40);
        rd_reg(tmr8_pkg::ADDR_IRQ_FLAGS, d);
        check(d, 8'h06);
        check({5'h00, irq}, 8'h06);
        wr_reg(tmr8_pkg::ADDR_IRQ_FLAGS, 8'h02);
        wr_reg(tmr8_pkg::ADDR_IRQ_FLAGS, 8'h00);
        rd_reg(tmr8_pkg::ADDR_IRQ_FLAGS, d);
        check(d, 8'h04);
        @(posedge clk_sys_in);
        ack <= 3'h4;
        @(posedge clk_sys_in);
        ack <= 3'h0;
        idle(2);
        rd_reg(tmr8_pkg::ADDR_IRQ_FLAGS, d);
        check(d, 8'h00);
        // Overflow with the global bit off, then on
        gie <= 1'b0;
        wr_reg(tmr8_pkg::ADDR_COUNT, 8'hf8);
        run(tmr8_pkg::CS_DIV1, 20);
        rd_reg(tmr8_pkg::ADDR_IRQ_FLAGS, d);
        check(d, 8'h01);
        check({5'h00, irq}, 8'h00);
        gie <= 1'b1;
        idle(2);
        check({5'h00, irq}, 8'h01);
        wr_reg(tmr8_pkg::ADDR_IRQ_FLAGS, 8'h01);
        // A count write hides the match on the first tick after it
        wr_reg(tmr8_pkg::ADDR_CMP_A, 8'h40);
        wr_reg(tmr8_pkg::ADDR_COUNT, 8'h40);
        run(tmr8_pkg::CS_DIV1, 0);
        rd_reg(tmr8_pkg::ADDR_IRQ_FLAGS, d);
        check(d, 8'h00);
        // Forced compares: outputs move, no flag, no counter change
        act_a <= tmr8_pkg::ACT_SET;
        act_b <= tmr8_pkg::ACT_TOGGLE;
        wr_reg(tmr8_pkg::ADDR_COUNT, 8'h33);
        wr_reg(tmr8_pkg::ADDR_CTRL_B, 8'hc0);
        idle(2);
        check({6'h00, wa, wb}, 8'h03);
        rd_reg(tmr8_pkg::ADDR_IRQ_FLAGS, d);
        check(d, 8'h00);
        rd_reg(tmr8_pkg::ADDR_COUNT, d);
        check(d, 8'h33);
        // In a PWM mode a force must do nothing
        wlow <= 2'h3;
        act_a <= tmr8_pkg::ACT_CLEAR;
        wr_reg(tmr8_pkg::ADDR_CTRL_B, 8'h80);
        idle(2);
        check({7'h00, wa}, 8'h01);
        wr_reg(tmr8_pkg::ADDR_CTRL_B, 8'h00);
        results();
    end
endmodule
`default_nettype wire
